/* File: verilog/adc_irq_pkg.sv */
package adc_irq_pkg;

  // register offsets (byte addresses)
  localparam logic [31:0] MASK_OFFSET     = 32'h40030004;
  localparam logic [31:0] MODE_OFFSET     = 32'h40030008;
  localparam logic [31:0] FLAGS_OFFSET    = 32'h40030000;
  localparam logic [31:0] CURDATA_OFFSET  = 32'h40030010;
  localparam logic [31:0] IRQ_STAT_OFFSET = 32'h40030020;
  localparam logic [31:0] IRQ_CLR_OFFSET  = 32'h40030024;
  localparam logic [31:0] IRQ_EN_OFFSET   = 32'h40030028;

  // reset values
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h03;

  // status flag positions
  localparam int CUR_READY_BIT   = 0;
  localparam int VOLT_READY_BIT  = 1;
  localparam int TEMP_READY_BIT  = 2;
  localparam int CUR_OVR_BIT     = 3;
  localparam int CUR_CMP_BIT     = 4;
  localparam int CUR_ACC_BIT     = 5;
  localparam int ALWAYS_IRQ_BIT  = 6;
  localparam int NUM_FLAGS       = 7;

  // mode register fields
  localparam int ALWAYS_IRQ_ENABLE_BIT = 5;
  localparam int MODE_FIELD_LSB        = 0;
  localparam int MODE_FIELD_W          = 3;
  localparam logic [2:0] MODE_IDLE     = 3'h3;
  localparam logic [2:0] MODE_DOWN     = 3'h0;

  // local irq status bits
  localparam int EV_MODE_WRITE = 0;
  localparam int EV_SETTLED    = 1;
  localparam int EV_OVERWRITE  = 2;
  localparam int NUM_EVENTS    = 3;

  // filter settling and output period, in ns
  localparam int SETTLE_NS        = 20000;
  localparam int CLK_PERIOD_NS    = 40;
  localparam int SETTLE_CYCLES    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OUT_PERIOD_NS    = 4000;
  localparam int OUT_PERIOD_CYCLES = OUT_PERIOD_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic        write;
    logic        read;
    logic [31:0] addr;
    logic [31:0] wdata;
  } bus_req_s;

  typedef struct packed {
    logic        valid;
    logic [23:0] data;
  } conv_result_s;

endpackage

/* File: verilog/sticky_flag.sv */
`timescale 1ns/10ps
module sticky_flag (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // control
  input  wire logic set,
  input  wire logic clear,
  // state
  output logic      flag
);

  logic next_flag;

  // a set in the clear cycle wins so no event is lost
  always_comb begin
    next_flag = flag;
    if (clear) begin
      next_flag = 1'b0;
    end
    if (set) begin
      next_flag = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      flag <= 1'b0;
    end else begin
      flag <= next_flag;
    end
  end

endmodule

/* File: verilog/adc_irq_ctrl.sv */
`timescale 1ns/10ps
module adc_irq_ctrl #(
  parameter int SETTLE_CYCLES = adc_irq_pkg::SETTLE_CYCLES,
  parameter int PERIOD_CYCLES = adc_irq_pkg::OUT_PERIOD_CYCLES
) (
  // clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RESET_N,
  // register port
  input  wire logic [31:0] ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WRITE,
  input  wire logic        READ,
  output logic      [31:0] RDATA,
  // converter side
  input  wire logic        CUR_DONE,
  input  wire logic [23:0] CUR_RESULT,
  input  wire logic        VOLT_DONE,
  input  wire logic        TEMP_DONE,
  input  wire logic        CUR_OVR,
  input  wire logic        CUR_CMP_HIT,
  input  wire logic        CUR_ACC_HIT,
  output logic             CONV_RESTART,
  output logic      [2:0]  CONV_MODE,
  // interrupts
  output logic             CONV_IRQ,
  output logic             SYS_IRQ
);

  localparam int NF = adc_irq_pkg::NUM_FLAGS;
  localparam int NE = adc_irq_pkg::NUM_EVENTS;

  adc_irq_pkg::bus_req_s     req;
  adc_irq_pkg::conv_result_s cur;
  logic [7:0]  mask;
  logic [7:0]  next_mask;
  logic [7:0]  mode;
  logic [7:0]  next_mode;
  logic [23:0] cur_data;
  logic [23:0] next_cur_data;
  logic [31:0] rdata_q;
  logic [31:0] next_rdata;
  logic [15:0] settle_cnt;
  logic [15:0] next_settle_cnt;
  logic [15:0] period_cnt;
  logic [15:0] next_period_cnt;
  logic        settled;
  logic        mode_wr;
  logic        cur_read;
  logic        always_on;
  logic        active;
  logic        period_tick;
  logic [NF-1:0] flag_set;
  logic [NF-1:0] flag_clr;
  logic [NF-1:0] conv_flag_register;
  logic [NE-1:0] ev_set;
  logic [NE-1:0] ev_clr;
  logic [NE-1:0] ev_stat;
  logic [NE-1:0] ev_en;
  logic [NE-1:0] next_ev_en;

  assign req = '{write: WRITE, read: READ, addr: ADDR, wdata: WDATA};
  assign cur = '{valid: CUR_DONE, data: CUR_RESULT};

  ////////////////////////////////////////////////////////////////////////
  // decode and mode

  assign mode_wr   = req.write && (req.addr == adc_irq_pkg::MODE_OFFSET);
  assign cur_read  = req.read && (req.addr == adc_irq_pkg::CURDATA_OFFSET);
  assign always_on = mode[adc_irq_pkg::ALWAYS_IRQ_ENABLE_BIT];
  // powered-down and idle hold the converters, so nothing counts there
  assign active = (mode[2:0] != adc_irq_pkg::MODE_IDLE) &&
                  (mode[2:0] != adc_irq_pkg::MODE_DOWN);
  assign settled      = (settle_cnt == 16'h0000);
  assign period_tick  = active && (period_cnt == 16'h0000);
  assign CONV_RESTART = mode_wr;
  assign CONV_MODE    = mode[2:0];

  ////////////////////////////////////////////////////////////////////////
  // status flags

  always_comb begin
    flag_set = '0;
    flag_clr = '0;
    // results are withheld while the filter settles
    if (settled && active && !mode_wr) begin
      flag_set[adc_irq_pkg::CUR_READY_BIT]  = cur.valid;
      flag_set[adc_irq_pkg::VOLT_READY_BIT] = VOLT_DONE;
      flag_set[adc_irq_pkg::TEMP_READY_BIT] = TEMP_DONE;
      flag_set[adc_irq_pkg::CUR_OVR_BIT]    = CUR_OVR;
      flag_set[adc_irq_pkg::CUR_CMP_BIT]    = CUR_CMP_HIT;
      flag_set[adc_irq_pkg::CUR_ACC_BIT]    = CUR_ACC_HIT;
    end
    // early interrupt ignores settling, not the restart itself
    flag_set[adc_irq_pkg::ALWAYS_IRQ_BIT] = always_on && period_tick && !mode_wr;
    if (mode_wr) begin
      flag_clr = '1;
    end
    if (cur_read) begin
      flag_clr[adc_irq_pkg::CUR_READY_BIT] = 1'b1;
      flag_clr[adc_irq_pkg::ALWAYS_IRQ_BIT] = 1'b1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NF; gi++) begin : g_flag
      sticky_flag u_flag (
        .clk     (SYS_CLK),
        .reset_n (RESET_N),
        .set     (flag_set[gi]),
        .clear   (flag_clr[gi]),
        .flag    (conv_flag_register[gi])
      );
    end
    for (gi = 0; gi < NE; gi++) begin : g_ev
      sticky_flag u_ev (
        .clk     (SYS_CLK),
        .reset_n (RESET_N),
        .set     (ev_set[gi]),
        .clear   (ev_clr[gi]),
        .flag    (ev_stat[gi])
      );
    end
  endgenerate

  // bit i of the mask gates flag i; bit 7 gates nothing
  assign CONV_IRQ = |(conv_flag_register & mask[NF-1:0]);
  assign SYS_IRQ  = |(ev_stat & ev_en);

  ////////////////////////////////////////////////////////////////////////
  // block events

  always_comb begin
    ev_set = '0;
    ev_set[adc_irq_pkg::EV_MODE_WRITE] = mode_wr;
    ev_set[adc_irq_pkg::EV_SETTLED]    = active && (settle_cnt == 16'h0001);
    ev_set[adc_irq_pkg::EV_OVERWRITE]  =
      cur.valid && conv_flag_register[adc_irq_pkg::CUR_READY_BIT];
    ev_clr = '0;
    if (req.write && (req.addr == adc_irq_pkg::IRQ_CLR_OFFSET)) begin
      ev_clr = req.wdata[NE-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // software registers

  // mask bit 7 is stored as written; it gates nothing
  always_comb begin
    next_mask  = mask;
    next_mode  = mode;
    next_ev_en = ev_en;
    if (req.write) begin
      case (req.addr)
        adc_irq_pkg::MASK_OFFSET: begin
          next_mask = req.wdata[7:0];
        end
        adc_irq_pkg::MODE_OFFSET: begin
          next_mode = req.wdata[7:0];
        end
        adc_irq_pkg::IRQ_EN_OFFSET: begin
          next_ev_en = req.wdata[NE-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      mask  <= adc_irq_pkg::MASK_RESET;
      mode  <= adc_irq_pkg::MODE_RESET;
      ev_en <= '0;
    end else begin
      mask  <= next_mask;
      mode  <= next_mode;
      ev_en <= next_ev_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // current result data

  always_comb begin
    next_cur_data = cur_data;
    // data register frozen while the ready flag is up
    if (cur.valid && settled && active &&
        !conv_flag_register[adc_irq_pkg::CUR_READY_BIT]) begin
      next_cur_data = cur.data;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      cur_data <= 24'h000000;
    end else begin
      cur_data <= next_cur_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // settling and output period counters

  // separate counters, so a period tick never shortens the settle wait
  always_comb begin
    next_settle_cnt = settle_cnt;
    next_period_cnt = period_cnt;
    if (mode_wr) begin
      next_settle_cnt = 16'(SETTLE_CYCLES);
      next_period_cnt = 16'(PERIOD_CYCLES - 1);
    end else begin
      if (!settled && active) begin
        next_settle_cnt = settle_cnt - 16'h0001;
      end
      if (active) begin
        if (period_tick) begin
          next_period_cnt = 16'(PERIOD_CYCLES - 1);
        end else begin
          next_period_cnt = period_cnt - 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      settle_cnt <= 16'h0000;
      period_cnt <= 16'h0000;
    end else begin
      settle_cnt <= next_settle_cnt;
      period_cnt <= next_period_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data

  // zero outside the answer cycle, so a stale value is never seen twice
  always_comb begin
    next_rdata = 32'h00000000;
    if (req.read) begin
      case (req.addr)
        adc_irq_pkg::FLAGS_OFFSET: begin
          next_rdata = {25'h0, conv_flag_register};
        end
        adc_irq_pkg::MASK_OFFSET: begin
          next_rdata = {24'h0, mask};
        end
        adc_irq_pkg::MODE_OFFSET: begin
          next_rdata = {24'h0, mode};
        end
        adc_irq_pkg::CURDATA_OFFSET: begin
          next_rdata = {8'h0, cur_data};
        end
        adc_irq_pkg::IRQ_STAT_OFFSET: begin
          next_rdata = {29'h0, ev_stat};
        end
        adc_irq_pkg::IRQ_EN_OFFSET: begin
          next_rdata = {29'h0, ev_en};
        end
        default: begin
          next_rdata = 32'h00000000;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= next_rdata;
    end
  end

  assign RDATA = rdata_q;

endmodule

/* File: verification/adc_irq_ctrl_props.sv */
`timescale 1ns/10ps
module adc_irq_props #(
  parameter int SETTLE_CYCLES = 8,
  parameter int PERIOD_CYCLES = 4
) (
  input wire logic        SYS_CLK, RESET_N, WRITE, READ,
  input wire logic [31:0] ADDR, WDATA, RDATA,
  input wire logic        CUR_DONE, VOLT_DONE, TEMP_DONE, CUR_OVR, CUR_CMP_HIT, CUR_ACC_HIT,
  input wire logic [23:0] CUR_RESULT,
  input wire logic        CONV_RESTART, CONV_IRQ, SYS_IRQ,
  input wire logic [2:0]  CONV_MODE
);
  // shadow of the mask, rebuilt from the bus since only ports are visible
  logic [7:0] mask;
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) mask <= 8'h00;
    else if (WRITE && ADDR == adc_irq_pkg::MASK_OFFSET) mask <= WDATA[7:0];
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  ////////////////////////////////////////////////////////////////
  AST_RESTART: assert property (CONV_RESTART == (WRITE && ADDR == adc_irq_pkg::MODE_OFFSET))
    else $error("restart not tied to mode write");
  AST_FLAGS_CLR: assert property (CONV_RESTART |=> !CONV_IRQ)
    else $error("irq survived mode write");
  AST_SETTLE: assert property (CONV_RESTART && !WDATA[5] |=> !CONV_IRQ [*7])
    else $error("irq before filter settled");
  AST_ALWAYS: assert property (CONV_RESTART && WDATA[5] && WDATA[2:0] == 3'h1 && mask[6]
    |-> ##[1:8] CONV_IRQ) else $error("always irq missing");
  AST_MASKED: assert property (mask[6:0] == 7'h00 |-> !CONV_IRQ)
    else $error("irq with all sources masked");
  AST_MASK_READ: assert property ($past(READ && ADDR == adc_irq_pkg::MASK_OFFSET)
    |-> RDATA == {24'h000000, $past(mask)}) else $error("mask readback wrong");
  AST_READ_CLR: assert property ($past(READ && ADDR == adc_irq_pkg::CURDATA_OFFSET)
    && !$past(CUR_DONE) && mask == 8'h01 |-> !CONV_IRQ) else $error("ready kept after read");
  AST_IDLE_RESET: assert property (!$past(RESET_N) |-> CONV_MODE == adc_irq_pkg::MODE_IDLE)
    else $error("mode not idle after reset");
  cover property (CONV_IRQ && mask[6]);
  cover property (CONV_RESTART ##1 !CONV_IRQ);
  cover property (SYS_IRQ);
endmodule
bind adc_irq_ctrl adc_irq_props #(.SETTLE_CYCLES(SETTLE_CYCLES), .PERIOD_CYCLES(PERIOD_CYCLES))
  u_props (.*);

/* File: verification/adc_irq_ctrl_tb.sv */
`timescale 1ns/10ps
module adc_irq_ctrl_tb;
  // short counts keep the run brief
  localparam int ST = 8;
  logic        SYS_CLK = 1'b0;
  logic        RESET_N = 1'b0;
  logic [31:0] ADDR = 32'h0, WDATA = 32'h0, RDATA;
  logic        WRITE = 1'b0, READ = 1'b0;
  logic [5:0]  ev = 6'h00;
  logic [23:0] res = 24'h000000;
  logic        CONV_RESTART, CONV_IRQ, SYS_IRQ;
  logic [2:0]  CONV_MODE;
  int          err_total = 0;
  int          cmp_count = 0;
  int          n;
  always #20 SYS_CLK = ~SYS_CLK;
  adc_irq_ctrl #(.SETTLE_CYCLES(ST), .PERIOD_CYCLES(4)) u_dut (
    .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .ADDR(ADDR), .WDATA(WDATA), .WRITE(WRITE),
    .READ(READ), .RDATA(RDATA), .CUR_DONE(ev[0]), .CUR_RESULT(res), .VOLT_DONE(ev[1]),
    .TEMP_DONE(ev[2]), .CUR_OVR(ev[3]), .CUR_CMP_HIT(ev[4]), .CUR_ACC_HIT(ev[5]),
    .CONV_RESTART(CONV_RESTART), .CONV_MODE(CONV_MODE), .CONV_IRQ(CONV_IRQ), .SYS_IRQ(SYS_IRQ));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // each task ends 1 ns past its last edge so registered effects have landed
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    WRITE <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge SYS_CLK);
    WRITE <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    @(posedge SYS_CLK);
    READ <= 1'b1;
    ADDR <= a;
    @(posedge SYS_CLK);
    READ <= 1'b0;
    #1 chk(RDATA, exp);
  endtask
  task automatic pulse(input logic [5:0] v, input logic [23:0] r);
    @(posedge SYS_CLK);
    ev <= v;
    res <= r;
    @(posedge SYS_CLK);
    ev <= 6'h00;
    #1;
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge SYS_CLK);
    err_total++;
    stop_test();
  end
  initial begin
    repeat (8) @(posedge SYS_CLK);
    RESET_N <= 1'b1;
    rd(adc_irq_pkg::MASK_OFFSET, 32'h00);
    rd(adc_irq_pkg::MODE_OFFSET, 32'h03);
    chk(CONV_MODE, 3'h3);
    $display("reset test done");
    for (int i = 0; i < 6; i++) begin
      wr(adc_irq_pkg::MODE_OFFSET, 32'h01);
      pulse(6'h01 << i, 24'h000000);
      rd(adc_irq_pkg::FLAGS_OFFSET, 32'h00);
      repeat (ST + 4) @(posedge SYS_CLK);
      pulse(6'h01 << i, 24'h000000);
      chk(CONV_IRQ, 1'b0);
      rd(adc_irq_pkg::FLAGS_OFFSET, 32'h01 << i);
      wr(adc_irq_pkg::MASK_OFFSET, 32'h01 << i);
      chk(CONV_IRQ, 1'b1);
      wr(adc_irq_pkg::MODE_OFFSET, 32'h01);
      chk(CONV_IRQ, 1'b0);
      wr(adc_irq_pkg::MASK_OFFSET, 32'h00);
    end
    $display("mask test done");
    wr(adc_irq_pkg::MASK_OFFSET, 32'h07);
    repeat (ST + 4) @(posedge SYS_CLK);
    pulse(6'h01, 24'hABCDEF);
    pulse(6'h01, 24'h123456);
    chk(CONV_IRQ, 1'b1);
    wr(adc_irq_pkg::MASK_OFFSET, 32'h01);
    chk(CONV_IRQ, 1'b1);
    rd(adc_irq_pkg::CURDATA_OFFSET, 32'hABCDEF);
    chk(CONV_IRQ, 1'b0);
    $display("data test done");
    wr(adc_irq_pkg::MASK_OFFSET, 32'h40);
    wr(adc_irq_pkg::MODE_OFFSET, 32'h21);
    n = 0;
    while (CONV_IRQ !== 1'b1 && n < 12) begin
      @(posedge SYS_CLK);
      #1 n++;
    end
    chk(CONV_IRQ && n < 7, 1'b1);
    rd(adc_irq_pkg::FLAGS_OFFSET, 32'h40);
    $display("always test done");
    chk(SYS_IRQ, 1'b0);
    wr(adc_irq_pkg::IRQ_EN_OFFSET, 32'h07);
    chk(SYS_IRQ, 1'b1);
    repeat (ST + 4) @(posedge SYS_CLK);
    wr(adc_irq_pkg::IRQ_CLR_OFFSET, 32'h07);
    rd(adc_irq_pkg::IRQ_STAT_OFFSET, 32'h00);
    chk(SYS_IRQ, 1'b0);
    rd(32'h40030030, 32'h00);
    $display("event test done");
    stop_test();
  end
endmodule
